// ### rtl/ivn_consts.vh
// Constants of the interrupt vector and non-maskable request controller.
// Assumes byte addresses on a plain register port with 32-bit data.
`ifndef IVN_CONSTS_VH
`define IVN_CONSTS_VH

// ==========================================================
// Register byte offsets
`define IVN_OFS_LEVEL_BASE 10'h000
`define IVN_OFS_LEVEL_LAST 10'h0BC
`define IVN_OFS_HALT_CTRL 10'h100
`define IVN_OFS_DELAY_SRC 10'h104
`define IVN_OFS_TABLE_BASE 10'h108
`define IVN_OFS_CURRENT 10'h10C
`define IVN_OFS_EVT_STATUS 10'h110
`define IVN_OFS_EVT_CLEAR 10'h114
`define IVN_OFS_EVT_ENABLE 10'h118

// ==========================================================
// Field positions
`define IVN_HALT_FLAG_BIT 0
`define IVN_DELAY_BIT 0
`define IVN_EVT_NMI_BIT 0
`define IVN_EVT_HALT_BIT 1
`define IVN_EVT_NEWREQ_BIT 2
`define IVN_EVT_WIDTH 3

// ==========================================================
// Reset values and fixed codes
`define IVN_LEVEL_RESET 5'h1F
`define IVN_LEVEL_MASKED 5'h1F
`define IVN_TABLE_BASE_RESET 32'h000FFC00
`define IVN_VEC_TOP_OFS 32'h000003FC
`define IVN_NMI_LEVEL 5'h0F
`define IVN_NMI_NUMBER 7'h0F
`define IVN_FIRST_SRC_NUMBER 7'h10
`define IVN_SRC_COUNT 48

`endif

// ### rtl/ivn_prio_sel.v
// Priority selection over the level-register sources.
// Assumes one level register of 5 bits per source, flattened low source first.
`include "ivn_consts.vh"

module ivn_prio_sel #(
    parameter N = 48
) (
    // Requests and their levels
    input wire [N-1:0] req,
    input wire [5*N-1:0] levels,
    // Winner
    output reg found,
    output reg [5:0] best_idx,
    output reg [4:0] best_lvl
);
    integer i;
    reg [4:0] lvl;

    // ==========================================================
    // Lowest level value wins; scanning downward makes the lowest number win ties
    always @* begin
        lvl = 5'h00;
        found = 1'b0;
        best_idx = 6'h00;
        best_lvl = `IVN_LEVEL_MASKED;
        for (i = N - 1; i >= 0; i = i - 1) begin
            lvl = levels[5*i +: 5];
            if (req[i] && lvl != `IVN_LEVEL_MASKED && (!found || lvl <= best_lvl)) begin
                found = 1'b1;
                best_idx = i[5:0];
                best_lvl = lvl;
            end
        end
    end
endmodule // ivn_prio_sel

// ### rtl/ivn_vec_calc.v
// Vector slot address from table base and interrupt number.
// Assumes a table of 256 word slots, number 0 at the top slot.
`include "ivn_consts.vh"

module ivn_vec_calc (
    // Operands
    input wire [31:0] table_base,
    input wire [7:0] number,
    // Result
    output wire [31:0] vec_addr
);
    // ==========================================================
    // Address arithmetic
    assign vec_addr = table_base + `IVN_VEC_TOP_OFS - {22'h000000, number, 2'b00}; // R12
endmodule // ivn_vec_calc

// ### rtl/ivn_intc.v
// Interrupt controller: maps sources to numbers, levels and vector slots.
// Assumes requests come from logic on clk; the non-maskable request is already
// detected by the external interrupt controller and arrives as a level.
//
// Function
// R1: A pending non-maskable request outranks every other handled source.
// R2: Coinciding with other requests, the non-maskable request is always selected.
// R3: Non-maskable delivery presents level 15 (01111) and number 15 (0001111).
// R4: No pin detection here; accept request, produce level, number, halt flag.
// R5: Non-maskable request sets the DMA-halt flag; DMA suppressed while set.
// R6: Software writes 0 to the DMA-halt flag to clear it; device clears. Here only that write or reset clears it.
// R7: DMA channel 0 events use number 31 with level register 15.
// R8: DMA channel 1 events use number 32 with level register 16.
// R9: DMA channel 2 events use number 33 with level register 17.
// R10: Software delayed interrupt bit is number 63 with level register 47.
// R11: Numbers 80 to 255 have no hardware source and no level register.
// R12: Vector address is table base plus 0x3FC minus four times the number.
`include "ivn_consts.vh"

module ivn_intc #(
    parameter N_SRC = 48
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Register port
    input wire [9:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Interrupt sources, numbers 16 to 62; number 63 is the delayed bit
    input wire [N_SRC-2:0] src_req,
    input wire nmi_req,
    // Processor side
    output reg int_valid,
    output reg [4:0] int_level,
    output reg [6:0] int_number,
    output reg [31:0] int_vector,
    // DMA and system interrupt
    output reg dma_halt,
    output reg irq
);
    // ==========================================================
    // Register state
    reg [4:0] level_r [0:N_SRC-1];
    reg halt_flag_r;
    reg delay_src_r;
    reg [31:0] table_base_r;
    reg [`IVN_EVT_WIDTH-1:0] evt_status_r;
    reg [`IVN_EVT_WIDTH-1:0] evt_enable_r;
    reg prev_valid_r;

    wire [5:0] reg_idx;
    wire level_hit;
    wire [N_SRC-1:0] all_req;
    wire [5*N_SRC-1:0] levels_flat;
    wire sel_found;
    wire [5:0] sel_idx;
    wire [4:0] sel_lvl;
    reg sel_valid_nxt;
    reg [4:0] sel_level_nxt;
    reg [6:0] sel_number_nxt;
    wire [31:0] vec_addr;
    reg [`IVN_EVT_WIDTH-1:0] evt_set;
    reg [31:0] rdata_nxt;
    integer k;
    genvar g;

    function is_reg;
        input [9:0] a;
        input [9:0] ofs;
        begin
            is_reg = (a == ofs);
        end
    endfunction

    assign reg_idx = reg_addr[7:2];
    assign level_hit = (reg_addr[1:0] == 2'b00) && (reg_addr <= `IVN_OFS_LEVEL_LAST);

    // ==========================================================
    // Source mapping: number = 16 + index, level register = index.
    // Index 15/16/17 carry the DMA channel 0/1/2 end or error events.
    assign all_req = {delay_src_r, src_req}; // R7 R8 R9 R10

    generate
        for (g = 0; g < N_SRC; g = g + 1) begin : g_flat
            assign levels_flat[5*g +: 5] = level_r[g];
        end
    endgenerate

    ivn_prio_sel #(
        .N(N_SRC)
    ) u_sel (
        .req(all_req),
        .levels(levels_flat),
        .found(sel_found),
        .best_idx(sel_idx),
        .best_lvl(sel_lvl)
    );

    // ==========================================================
    // Delivery choice; the non-maskable request bypasses the level table
    always @* begin
        sel_valid_nxt = 1'b0;
        sel_level_nxt = `IVN_LEVEL_MASKED;
        sel_number_nxt = 7'h00;
        if (nmi_req) begin // R1 R2 R4
            sel_valid_nxt = 1'b1;
            sel_level_nxt = `IVN_NMI_LEVEL; // R3
            sel_number_nxt = `IVN_NMI_NUMBER; // R3
        end else if (sel_found) begin
            sel_valid_nxt = 1'b1;
            sel_level_nxt = sel_lvl;
            // Highest reachable hardware number is 63; 80 and up stay trap-only
            sel_number_nxt = `IVN_FIRST_SRC_NUMBER + {1'b0, sel_idx}; // R11
        end
    end

    ivn_vec_calc u_vec (
        .table_base(table_base_r),
        .number({1'b0, sel_number_nxt}),
        .vec_addr(vec_addr)
    );

    // ==========================================================
    // Processor outputs, registered
    always @(posedge clk) begin
        if (reset) begin
            int_valid <= 1'b0;
            int_level <= `IVN_LEVEL_MASKED;
            int_number <= 7'h00;
            int_vector <= 32'h00000000;
        end else begin
            int_valid <= sel_valid_nxt;
            int_level <= sel_level_nxt;
            int_number <= sel_number_nxt;
            int_vector <= sel_valid_nxt ? vec_addr : 32'h00000000; // R12
        end
    end

    // ==========================================================
    // Level registers, delayed source bit and table base
    always @(posedge clk) begin
        if (reset) begin
            for (k = 0; k < N_SRC; k = k + 1) begin
                level_r[k] <= `IVN_LEVEL_RESET;
            end
            delay_src_r <= 1'b0;
            table_base_r <= `IVN_TABLE_BASE_RESET; // R12
        end else if (reg_wr) begin
            if (level_hit) begin
                level_r[reg_idx] <= reg_wdata[4:0];
            end
            if (is_reg(reg_addr, `IVN_OFS_DELAY_SRC)) begin
                delay_src_r <= reg_wdata[`IVN_DELAY_BIT]; // R10
            end
            // Slots are words, so the low two base bits are kept zero
            if (is_reg(reg_addr, `IVN_OFS_TABLE_BASE)) begin
                table_base_r <= {reg_wdata[31:2], 2'b00};
            end
        end
    end

    // ==========================================================
    // DMA-halt flag: set by the non-maskable request, cleared by writing 0.
    // Set wins so a request landing on the clearing write is not lost.
    always @(posedge clk) begin
        if (reset) begin
            halt_flag_r <= 1'b0;
        end else if (nmi_req) begin
            halt_flag_r <= 1'b1; // R5
        end else if (reg_wr && is_reg(reg_addr, `IVN_OFS_HALT_CTRL)
                     && !reg_wdata[`IVN_HALT_FLAG_BIT]) begin
            halt_flag_r <= 1'b0; // R6
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            dma_halt <= 1'b0;
        end else begin
            dma_halt <= halt_flag_r | nmi_req; // R5
        end
    end

    // ==========================================================
    // Event status, clear and enable; set wins over clear
    always @* begin
        evt_set = {`IVN_EVT_WIDTH{1'b0}};
        evt_set[`IVN_EVT_NMI_BIT] = nmi_req;
        evt_set[`IVN_EVT_HALT_BIT] = nmi_req && !halt_flag_r;
        evt_set[`IVN_EVT_NEWREQ_BIT] = sel_valid_nxt && !prev_valid_r;
    end

    always @(posedge clk) begin
        if (reset) begin
            evt_status_r <= {`IVN_EVT_WIDTH{1'b0}};
            evt_enable_r <= {`IVN_EVT_WIDTH{1'b0}};
            prev_valid_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            prev_valid_r <= sel_valid_nxt;
            if (reg_wr && is_reg(reg_addr, `IVN_OFS_EVT_CLEAR)) begin
                evt_status_r <= (evt_status_r & ~reg_wdata[`IVN_EVT_WIDTH-1:0]) | evt_set;
            end else begin
                evt_status_r <= evt_status_r | evt_set;
            end
            if (reg_wr && is_reg(reg_addr, `IVN_OFS_EVT_ENABLE)) begin
                evt_enable_r <= reg_wdata[`IVN_EVT_WIDTH-1:0];
            end
            irq <= |(evt_status_r & evt_enable_r);
        end
    end

    // ==========================================================
    // Read path; data stand one cycle after the strobe and only then
    always @* begin
        rdata_nxt = 32'h00000000;
        if (level_hit) begin
            rdata_nxt = {27'h0000000, level_r[reg_idx]};
        end else if (is_reg(reg_addr, `IVN_OFS_HALT_CTRL)) begin
            rdata_nxt = {31'h00000000, halt_flag_r};
        end else if (is_reg(reg_addr, `IVN_OFS_DELAY_SRC)) begin
            rdata_nxt = {31'h00000000, delay_src_r};
        end else if (is_reg(reg_addr, `IVN_OFS_TABLE_BASE)) begin
            rdata_nxt = table_base_r;
        end else if (is_reg(reg_addr, `IVN_OFS_CURRENT)) begin
            rdata_nxt = {19'h00000, int_valid, int_level, int_number};
        end else if (is_reg(reg_addr, `IVN_OFS_EVT_STATUS)) begin
            rdata_nxt = {29'h00000000, evt_status_r};
        end else if (is_reg(reg_addr, `IVN_OFS_EVT_ENABLE)) begin
            rdata_nxt = {29'h00000000, evt_enable_r};
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule // ivn_intc

// ### dv/ivn_intc_sva.sv
// Checker for the interrupt controller, bound to its top-level ports.
// Assumes one clock and a synchronous active-high reset.
module ivn_intc_sva #(
    parameter N_SRC = 48
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // Requests and delivery
    input wire logic [N_SRC-2:0] src_req,
    input wire logic nmi_req,
    input wire logic int_valid,
    input wire logic [4:0] int_level,
    input wire logic [6:0] int_number,
    input wire logic dma_halt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================================
    // Halt flag release
    sequence s_halt_clear;
        reg_wr && reg_addr == 10'h100 && !reg_wdata[0] && !nmi_req ##1 !nmi_req;
    endsequence
    // ==========================================================
    // Delivery and DMA-halt flag
    a_nmi_delivered: assert property (nmi_req |=> int_valid)
        else $error("nmi not delivered");
    a_nmi_beats_all: assert property (nmi_req && |src_req |=> int_number == 7'h0F)
        else $error("nmi lost to another source");
    a_nmi_codes: assert property (nmi_req |=> int_level == 5'h0F && int_number == 7'h0F)
        else $error("nmi level or number wrong");
    a_halt_set: assert property (nmi_req |=> dma_halt)
        else $error("halt flag not set");
    // Without a write the flag may only stay up
    a_halt_hold: assert property (dma_halt && !reg_wr && !$past(reg_wr) |=> dma_halt)
        else $error("halt flag dropped by itself");
    a_halt_clear: assert property (s_halt_clear |-> ##[0:1] !dma_halt)
        else $error("halt flag not cleared");
    a_dma0_num: assert property (int_valid && int_number == 7'h1F |-> $past(src_req[15]))
        else $error("number 31 without its source");
    a_dma1_num: assert property (int_valid && int_number == 7'h20 |-> $past(src_req[16]))
        else $error("number 32 without its source");
    a_dma2_num: assert property (int_valid && int_number == 7'h21 |-> $past(src_req[17]))
        else $error("number 33 without its source");
    a_no_trap_num: assert property (int_valid |-> int_number inside {[7'h0F:7'h3F]})
        else $error("delivered number outside hardware range");
endmodule // ivn_intc_sva

// ### dv/ivn_cpu_model.sv
// Processor-side model: latches each delivered request as the core would.
// Assumes the controller outputs are registered on clk.
module ivn_cpu_model (
    // Clock
    input wire logic clk,
    // Delivery from the controller
    input wire logic int_valid,
    input wire logic [4:0] int_level,
    input wire logic [6:0] int_number,
    // Last request taken
    output logic [4:0] took_level,
    output logic [6:0] took_number
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle cycles keep the last take, as the core only acts on a request
    always @(posedge clk) begin
        if (int_valid) begin
            took_level <= int_level;
            took_number <= int_number;
        end
    end
endmodule // ivn_cpu_model

// ### dv/ivn_intc_tb.sv
// Bench for the interrupt controller: register tasks and directed deliveries.
// Assumes the checker and the processor model are compiled before it.
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end
module ivn_intc_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] reg_addr = 10'h000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [46:0] src_req = 47'h000000000000;
    logic nmi_req = 1'b0;
    logic [31:0] reg_rdata, int_vector;
    logic int_valid, dma_halt, irq;
    logic [4:0] int_level, took_level;
    logic [6:0] int_number, took_number;
    int fail_count = 0;
    int compares = 0;
    always #20 clk = ~clk;
    ivn_intc #(.N_SRC(48)) u_ivn_intc (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_req(src_req), .nmi_req(nmi_req), .int_valid(int_valid), .int_level(int_level),
        .int_number(int_number), .int_vector(int_vector), .dma_halt(dma_halt), .irq(irq));
    ivn_cpu_model u_ivn_cpu_model (.clk(clk), .int_valid(int_valid), .int_level(int_level),
        .int_number(int_number), .took_level(took_level), .took_number(took_number));
    // ==========================================================
    // Tasks
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK("reg_rdata", exp, reg_rdata)
    endtask
    task automatic dlv(input logic [6:0] num, input logic [4:0] lvl, input logic [31:0] vec);
        repeat (2) @(posedge clk);
        #1 `CHK("int_number", num, int_number)
        `CHK("int_level", lvl, int_level)
        `CHK("int_vector", vec, int_vector)
        `CHK("took_number", num, took_number)
        `CHK("took_level", lvl, took_level)
    endtask
    // The flag is looked at after the wait, not copied when the task is called
    task automatic sig(input logic exp, input bit pick_irq);
        repeat (2) @(posedge clk);
        #1;
        if (pick_irq) `CHK("irq", exp, irq)
        else `CHK("dma_halt", exp, dma_halt)
    endtask
    task automatic complete_run;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(10'h108, 32'h000FFC00);
        rd(10'h000, 32'h0000001F);
        rd(10'h200, 32'h00000000);
        $display("test reset done");
        wr(10'h118, 32'h00000007);
        wr(10'h03C, 32'h00000000);
        src_req <= {47{1'b1}};
        nmi_req <= 1'b1;
        dlv(7'h0F, 5'h0F, 32'h000FFFC0);
        `CHK("dma_halt", 1'b1, dma_halt)
        @(posedge clk);
        nmi_req <= 1'b0;
        wr(10'h100, 32'h00000001);
        sig(1'b1, 1'b0);
        dlv(7'h1F, 5'h00, 32'h000FFF80);
        wr(10'h100, 32'h00000000);
        sig(1'b0, 1'b0);
        $display("test nmi done");
        sig(1'b1, 1'b1);
        rd(10'h110, 32'h00000007);
        wr(10'h118, 32'h00000000);
        sig(1'b0, 1'b1);
        wr(10'h118, 32'h00000007);
        sig(1'b1, 1'b1);
        wr(10'h114, 32'h00000007);
        sig(1'b0, 1'b1);
        rd(10'h110, 32'h00000000);
        $display("test irq done");
        // Masking the previous winner keeps the lowest-number tie-break out of the way
        for (int i = 15; i <= 17; i++) begin
            wr(10'(4 * i), 32'h00000000);
            dlv(7'(16 + i), 5'h00, 32'h000FFFFC - 32'(4 * (16 + i)));
            wr(10'(4 * i), 32'h0000001F);
        end
        src_req <= 47'h000000000000;
        wr(10'h104, 32'h00000001);
        wr(10'h0BC, 32'h00000002);
        wr(10'h108, 32'h00001000);
        dlv(7'h3F, 5'h02, 32'h00001300);
        rd(10'h10C, 32'h0000113F);
        rd(10'h0C0, 32'h00000000);
        $display("test sources done");
        complete_run();
    end
    initial begin
        repeat (4000) @(posedge clk);
        fail_count++;
        $display("watchdog expired");
        complete_run();
    end
endmodule // ivn_intc_tb
bind ivn_intc ivn_intc_sva #(.N_SRC(N_SRC)) u_ivn_intc_sva (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .src_req(src_req),
    .nmi_req(nmi_req), .int_valid(int_valid), .int_level(int_level),
    .int_number(int_number), .dma_halt(dma_halt));
